// ===== logic/fpm_dram_ctrl.sv
`timescale 1ns/1ps
module fpm_dram_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire fpm_dram_pkg::mem_req_t req,
  input wire logic req_page,
  input wire logic refresh_mode_cbr,
  output logic req_ready,
  output logic rd_valid,
  output logic [fpm_dram_pkg::DATA_W-1:0] rd_data,
  output logic init_done,
  output fpm_dram_pkg::dram_pins_t pins,
  output logic [fpm_dram_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [fpm_dram_pkg::DATA_W-1:0] dq_in
);

  typedef enum logic [8:0] {
    ST_POWERUP = 9'h001,
    ST_IDLE    = 9'h002,
    ST_RAS     = 9'h004,
    ST_CAS     = 9'h008,
    ST_CASPRE  = 9'h010,
    ST_RASHOLD = 9'h020,
    ST_PRECH   = 9'h040,
    ST_CBRSET  = 9'h080,
    ST_REFLOW  = 9'h100
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1_r, rst_s2_r;
  logic [fpm_dram_pkg::DATA_W-1:0] dq_s1_r, dq_s2_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_sync_n = rst_s2_r;

  // Data pins cross in from the module
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  state_t state_r, state_nxt;
  logic [17:0] tmr_r, tmr_nxt;
  logic [17:0] ref_tmr_r;
  logic [8:0] ref_pend_r;
  logic [3:0] init_cnt_r;
  logic [8:0] ref_row_r;
  logic [17:0] ras_tmr_r;
  logic [7:0] page_tmr_r;
  logic op_write_r, op_ref_r;
  fpm_dram_pkg::mem_req_t cur_r;
  logic accept, ref_start, ref_done;

  wire tmr_zero = (tmr_r == 18'h00000);
  wire ref_due = (ref_pend_r != 9'h000) || !init_done;
  wire [17:0] ras_limit = 18'(fpm_dram_pkg::RASC_CYC - fpm_dram_pkg::RHCP_CYC
                              - 4 * fpm_dram_pkg::PC_CYC);
  // Keep page open only while the row pulse has room for another column
  wire page_ok = req_valid && req_page && (req.row == cur_r.row) && !op_ref_r
                 && (ref_pend_r == 9'h000) && (ras_tmr_r < ras_limit);
  assign accept = (state_r == ST_IDLE) && tmr_zero && req_valid && !ref_due;
  assign ref_start = (state_r == ST_IDLE) && tmr_zero && ref_due;
  assign ref_done = (state_r == ST_PRECH) && tmr_zero && op_ref_r;
  wire use_cbr = refresh_mode_cbr && init_done;

  function automatic logic [17:0] ld(input int c);
    return 18'(c - 1);
  endfunction

  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_zero ? 18'h00000 : tmr_r - 18'h00001;
    unique case (state_r)
      ST_POWERUP: if (tmr_zero) begin
        state_nxt = ST_IDLE;
      end
      ST_IDLE: if (ref_start && use_cbr) begin
        state_nxt = ST_CBRSET;
        tmr_nxt = ld(fpm_dram_pkg::CSR_CYC);
      end else if (ref_start || accept) begin
        state_nxt = ST_RAS;
        tmr_nxt = ld(fpm_dram_pkg::RCD_CYC);
      end
      ST_RAS: if (tmr_zero) begin
        if (op_ref_r) begin
          state_nxt = ST_REFLOW;
          tmr_nxt = ld(fpm_dram_pkg::ROW_LOW_CYC);
        end else begin
          state_nxt = ST_CAS;
          tmr_nxt = ld(fpm_dram_pkg::CAS_ACCESS_CYC);
        end
      end
      ST_CBRSET: if (tmr_zero) begin
        state_nxt = ST_REFLOW;
        tmr_nxt = ld(fpm_dram_pkg::ROW_LOW_CYC);
      end
      ST_REFLOW: if (tmr_zero) begin
        state_nxt = ST_PRECH;
        tmr_nxt = ld(fpm_dram_pkg::RP_CYC);
      end
      ST_CAS: if (tmr_zero) begin
        if (page_ok) begin
          state_nxt = ST_CASPRE;
          tmr_nxt = ld(fpm_dram_pkg::CP_CYC);
        end else begin
          state_nxt = ST_RASHOLD;
          tmr_nxt = ld(fpm_dram_pkg::RHCP_CYC);
        end
      end
      ST_CASPRE: if (tmr_zero) begin
        state_nxt = ST_CAS;
        tmr_nxt = ld(fpm_dram_pkg::PAGE_ACCESS_CYC);
      end
      ST_RASHOLD: if (tmr_zero) begin
        state_nxt = ST_PRECH;
        tmr_nxt = ld(fpm_dram_pkg::RP_CYC);
      end
      ST_PRECH: if (tmr_zero) begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        tmr_nxt = 18'h00000;
      end
    endcase
  end

  wire page_accept = (state_r == ST_CAS) && tmr_zero && page_ok;
  wire cas_done = (state_r == ST_CAS) && tmr_zero;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= ST_POWERUP;
      tmr_r <= ld(fpm_dram_pkg::POWERUP_CYC);
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh bookkeeping; a tick in the same cycle as a done cancels it, leaving the count as it was
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_tmr_r <= '0;
      ref_pend_r <= '0;
      init_cnt_r <= '0;
      init_done <= 1'b0;
      ref_row_r <= '0;
    end else begin
      if (ref_tmr_r == ld(fpm_dram_pkg::REFRESH_INTERVAL_CYC)) begin
        ref_tmr_r <= '0;
        if (init_done && !ref_done) begin
          ref_pend_r <= ref_pend_r + 9'h001;
        end
      end else begin
        ref_tmr_r <= ref_tmr_r + 18'h00001;
        if (ref_done && init_done && ref_pend_r != 9'h000) begin
          ref_pend_r <= ref_pend_r - 9'h001;
        end
      end
      if (ref_done) begin
        ref_row_r <= ref_row_r + 9'h001;
        if (!init_done) begin
          init_cnt_r <= init_cnt_r + 4'h1;
          init_done <= (init_cnt_r == 4'(fpm_dram_pkg::INIT_CYCLES - 1));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur_r <= '0;
      op_write_r <= 1'b0;
      op_ref_r <= 1'b0;
      ras_tmr_r <= '0;
    end else begin
      if (accept || page_accept) begin
        cur_r <= req;
        op_write_r <= req.write;
      end
      if (ref_start) begin
        op_ref_r <= 1'b1;
        op_write_r <= 1'b0;
      end else if (accept) begin
        op_ref_r <= 1'b0;
      end
      ras_tmr_r <= (state_r == ST_IDLE) ? 18'h00000 : ras_tmr_r + 18'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  wire st_row_low = (state_r == ST_RAS) || (state_r == ST_CAS) || (state_r == ST_CASPRE)
                    || (state_r == ST_RASHOLD) || (state_r == ST_REFLOW);
  wire st_cas_low = (state_r == ST_CAS) || (state_r == ST_CBRSET)
                    || ((state_r == ST_REFLOW) && !op_ref_r)
                    || ((state_r == ST_REFLOW) && use_cbr);
  wire [fpm_dram_pkg::LANES-1:0] lane_sel = op_write_r ? cur_r.lanes : '1;
  wire [8:0] row_addr = op_ref_r ? ref_row_r : cur_r.row;
  wire col_phase = (state_r == ST_RAS) && !op_ref_r
                   && (tmr_r <= 18'(fpm_dram_pkg::RCD_CYC - fpm_dram_pkg::RAD_CYC));
  wire col_hold = (state_r == ST_CAS) || (state_r == ST_CASPRE) || (state_r == ST_RASHOLD);
  wire [8:0] addr_nxt = (col_phase || col_hold) ? cur_r.col : row_addr;
  wire cbr_pending = ref_start && use_cbr;
  wire ras_nxt_n = !((state_nxt == ST_RAS) || (state_nxt == ST_CAS)
                     || (state_nxt == ST_CASPRE) || (state_nxt == ST_RASHOLD)
                     || (state_nxt == ST_REFLOW));
  wire cas_nxt = (state_nxt == ST_CAS)
                 || ((state_nxt == ST_CBRSET) || ((state_nxt == ST_REFLOW) && use_cbr
                     && op_ref_r && (state_r != ST_RAS)));
  wire [8:0] addr_sel = (state_nxt == ST_RAS && state_r == ST_IDLE)
                        ? (ref_start ? ref_row_r : req.row) : addr_nxt;
  wire we_nxt_n = !(op_write_r && (state_nxt == ST_CAS || state_nxt == ST_CASPRE
                                   || state_nxt == ST_RAS) && !op_ref_r
                    || (accept && req.write));

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pins <= '{ras_n: 1'b1, cas_n: '1, we_n: 1'b1, addr: '0};
      dq_out <= '0;
      dq_oe <= 1'b0;
    end else begin
      pins.ras_n <= ras_nxt_n;
      pins.cas_n <= cas_nxt ? ~((state_nxt == ST_CAS) ? lane_sel : 4'hF) : 4'hF;
      pins.we_n <= we_nxt_n;
      pins.addr <= addr_sel;
      // Drive data only on writes; reads leave the bus to the module
      dq_oe <= !we_nxt_n;
      if (accept || page_accept) begin
        dq_out <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
      req_ready <= 1'b0;
    end else begin
      rd_valid <= cas_done && !op_write_r && !op_ref_r;
      if (cas_done && !op_write_r) begin
        rd_data <= dq_s2_r;
      end
      req_ready <= accept || page_accept;
    end
  end

endmodule

// ===== logic/fpm_dram_pkg.sv
package fpm_dram_pkg;

  localparam int CLK_PERIOD_PS = 5000;

  // Times as printed, in their own units
  localparam int POWERUP_PAUSE_US = 100;
  localparam int INIT_CYCLES = 8;
  localparam int REFRESH_PERIOD_MS = 8;
  localparam int REFRESH_ROWS = 512;
  localparam int ROW_TO_COL_STROBE_NS = 20;
  localparam int ROW_TO_COL_ADDR_NS = 15;
  localparam int ROW_ACCESS_NS = 60;
  localparam int COL_ACCESS_NS = 20;
  localparam int ADDR_ACCESS_NS = 30;
  localparam int PRECHARGE_ACCESS_NS = 40;
  localparam int READ_HOLD_AFTER_ROW_NS = 10;
  localparam int COL_ADDR_LEAD_NS = 30;
  localparam int OUTPUT_OFF_NS = 20;
  localparam int WRITE_PULSE_NS = 10;
  localparam int WRITE_DATA_HOLD_NS = 15;
  localparam int COL_HOLD_AFTER_ROW_NS = 60;
  localparam int COL_TO_ROW_PRE_NS = 10;
  localparam int REFRESH_COL_SETUP_NS = 10;
  localparam int REFRESH_COL_HOLD_NS = 15;
  localparam int ROW_PRE_TO_COL_NS = 10;
  localparam int PAGE_CYCLE_NS = 45;
  localparam int PAGE_COL_PRE_NS = 10;
  localparam int PAGE_ROW_PULSE_NS = 100000;
  localparam int ROW_HOLD_AFTER_PRE_NS = 40;
  localparam int ROW_PRECHARGE_NS = 55;

  function automatic int cyc_min(input longint ps);
    longint c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : int'(c);
  endfunction

  function automatic int cyc_max(input longint ps);
    longint c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : int'(c);
  endfunction

  // Cycle counts at 200 MHz
  localparam int POWERUP_CYC = cyc_min(longint'(POWERUP_PAUSE_US) * 1000000);
  localparam int REFRESH_INTERVAL_CYC =
    cyc_max(longint'(REFRESH_PERIOD_MS) * 1000000000 / REFRESH_ROWS);
  localparam int RCD_CYC = cyc_min(ROW_TO_COL_STROBE_NS * 1000);
  localparam int RAD_CYC = cyc_min(ROW_TO_COL_ADDR_NS * 1000);
  localparam int ACCESS_NS_MAX = (ROW_ACCESS_NS - ROW_TO_COL_STROBE_NS > COL_ACCESS_NS) ?
    ROW_ACCESS_NS - ROW_TO_COL_STROBE_NS : COL_ACCESS_NS;
  // Data lands on the access edge, then needs two synchroniser flops
  localparam int CAS_ACCESS_CYC = cyc_min(ACCESS_NS_MAX * 1000) + 3;
  localparam int PAGE_ACCESS_CYC = cyc_min(PRECHARGE_ACCESS_NS * 1000) + 1;
  localparam int CAS_LOW_CYC = cyc_min(COL_HOLD_AFTER_ROW_NS * 1000);
  localparam int CP_CYC = cyc_min(PAGE_COL_PRE_NS * 1000);
  localparam int PC_CYC = cyc_min(PAGE_CYCLE_NS * 1000);
  localparam int RHCP_CYC = cyc_min(ROW_HOLD_AFTER_PRE_NS * 1000);
  localparam int RRH_CYC = cyc_min(READ_HOLD_AFTER_ROW_NS * 1000);
  localparam int RP_CYC = cyc_min(ROW_PRECHARGE_NS * 1000);
  localparam int CSR_CYC = cyc_min(REFRESH_COL_SETUP_NS * 1000);
  localparam int CHR_CYC = cyc_min(REFRESH_COL_HOLD_NS * 1000);
  localparam int RASC_CYC = cyc_max(longint'(PAGE_ROW_PULSE_NS) * 1000);
  localparam int ROW_LOW_CYC = cyc_min(ROW_ACCESS_NS * 1000);

  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int CNT_W = 16;
  localparam logic [7:0] ROW_MAX = 8'hFF;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [LANES-1:0] lanes;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic ras_n;
    logic [LANES-1:0] cas_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
  } dram_pins_t;

endpackage

// ===== test/fpm_dram_checker.sv
`timescale 1ns/1ps
module fpm_dram_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic init_done,
  input wire fpm_dram_pkg::dram_pins_t pins,
  input wire logic [fpm_dram_pkg::DATA_W-1:0] dq_out,
  input wire logic dq_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire cas_hi = &pins.cas_n;
  logic cbr_r;
  logic open_r;
  int unsigned low_r;
  int unsigned gap_r;
  int unsigned boot_r;
  int unsigned nras_r;
  ////////////////////////////////////////
  // Open column: a column strobe fell after the row strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cbr_r <= 1'b0;
      open_r <= 1'b0;
      low_r <= 32'h0;
      gap_r <= 32'h0;
      boot_r <= 32'h0;
      nras_r <= 32'h0;
    end else begin
      cbr_r <= $fell(pins.ras_n) ? !cas_hi : cbr_r && !pins.ras_n;
      open_r <= !pins.ras_n && (open_r || (!cas_hi && !cbr_r && !$fell(pins.ras_n)));
      low_r <= pins.ras_n ? 32'h0 : low_r + 32'h1;
      gap_r <= $fell(pins.ras_n) ? 32'h0 : gap_r + 32'h1;
      boot_r <= (boot_r < fpm_dram_pkg::POWERUP_CYC) ? boot_r + 32'h1 : boot_r;
      nras_r <= nras_r + ($fell(pins.ras_n) ? 32'h1 : 32'h0);
    end
  end
  a_powerup_pause: assert property ($fell(pins.ras_n) |-> boot_r >= fpm_dram_pkg::POWERUP_CYC)
    else $error("row strobe during power-up pause");
  a_init_count: assert property ($rose(init_done) |-> nras_r >= 8)
    else $error("ready before eight row cycles");
  a_no_early_req: assert property (req_ready |-> init_done)
    else $error("request taken before init");
  a_refresh_gap: assert property (init_done |-> gap_r < fpm_dram_pkg::REFRESH_INTERVAL_CYC + 300)
    else $error("refresh interval exceeded");
  a_ras_to_cas: assert property ($fell(pins.ras_n) && cas_hi |-> cas_hi [*4])
    else $error("column strobe too early");
  a_read_we_hold: assert property ($rose(pins.ras_n) && pins.we_n |-> pins.we_n [*2])
    else $error("write strobe fell too soon after read");
  a_write_setup: assert property (!pins.ras_n && $past(cas_hi) && !cas_hi && !pins.we_n |->
    !$past(pins.we_n) ##1 (dq_oe && $stable(dq_out) && !pins.we_n) [*3])
    else $error("write data or strobe not held");
  a_cas_precharge: assert property ($fell(pins.ras_n) && cas_hi |-> $past(cas_hi, 2))
    else $error("column strobe precharge short");
  a_cbr_timing: assert property ($fell(pins.ras_n) && !cas_hi |->
    $past(!cas_hi, 2) && (!cas_hi) [*3])
    else $error("refresh column setup or hold short");
  a_cas_after_ras: assert property ($rose(pins.ras_n) |-> cas_hi [*2])
    else $error("column strobe low right after row rise");
  a_page_precharge: assert property ($rose(cas_hi) && open_r |-> cas_hi [*2])
    else $error("column precharge short");
  a_row_hold: assert property ($rose(cas_hi) && open_r |-> !pins.ras_n [*8])
    else $error("row strobe rose too soon");
  a_row_pulse_max: assert property (low_r < fpm_dram_pkg::RASC_CYC)
    else $error("row strobe held too long");
  c_cbr: cover property ($fell(pins.ras_n) && !cas_hi);
  c_write: cover property (open_r && !pins.we_n);
  c_page: cover property ($rose(cas_hi) && open_r ##[1:12] $fell(cas_hi) && open_r);
endmodule

// ===== test/fpm_dram_model.sv
`timescale 1ns/1ps
module fpm_dram_model (
  input wire fpm_dram_pkg::dram_pins_t pins,
  input wire logic [31:0] dq_out,
  input wire logic dq_oe,
  output logic [31:0] dq_in
);
  logic [31:0] mem [bit [17:0]];
  logic [8:0] row_r = 9'h000;
  logic [3:0] cas_q = 4'hF;
  logic [31:0] last = 32'h0;
  realtime t_ras = 0;
  realtime t_adr = 0;
  realtime t_up = 0;
  realtime due = 0;
  int unsigned seq = 0;
  initial dq_in = 32'hFFFFFFFF;
  function automatic logic [31:0] rd(input bit [17:0] k);
    return mem.exists(k) ? mem[k] : {14'h0, k};
  endfunction
  // Garbage until the latest access delay has run out
  task automatic drive(input int unsigned s, input realtime t, input logic [31:0] d);
    dq_in = ~last;
    #(t - $realtime);
    if (s == seq) begin
      dq_in = d;
      last = d;
    end
  endtask
  always @(pins.addr) t_adr = $realtime;
  always @(negedge pins.ras_n) begin
    t_ras = $realtime;
    if (&pins.cas_n) row_r = pins.addr;
  end
  always @(pins.cas_n) begin
    for (int i = 0; i < 4; i++) begin
      if (cas_q[i] && !pins.cas_n[i] && !pins.ras_n && !pins.we_n) begin
        mem[{row_r, pins.addr}] = rd({row_r, pins.addr});
        mem[{row_r, pins.addr}][8*i+:8] = dq_oe ? dq_out[8*i+:8] : ~dq_out[8*i+:8];
      end
    end
    if (cas_q[0] && !pins.cas_n[0] && !pins.ras_n && pins.we_n) begin
      due = $realtime + 20;
      due = (t_ras + 60 > due) ? t_ras + 60 : due;
      due = (t_adr + 30 > due) ? t_adr + 30 : due;
      due = (t_up > t_ras && t_up + 40 > due) ? t_up + 40 : due;
      fork
        drive(seq, due, rd({row_r, pins.addr}));
      join_none
    end
    if (!cas_q[0] && pins.cas_n[0]) begin
      seq++;
      t_up = $realtime;
      dq_in = ~last;
    end
    cas_q = pins.cas_n;
  end
endmodule

// ===== test/fpm_dram_ctrl_tb.sv
`timescale 1ns/1ps
module fpm_dram_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_page = 1'b0;
  logic refresh_mode_cbr = 1'b0;
  fpm_dram_pkg::mem_req_t req = '0;
  logic req_ready, rd_valid, init_done, dq_oe;
  logic [31:0] rd_data, dq_out, dq_in;
  fpm_dram_pkg::dram_pins_t pins;
  logic [31:0] exp_q[$];
  logic [31:0] ref_m [bit [17:0]];
  logic [31:0] lfsr = 32'h02BCAD82;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int ras_falls = 0;
  fpm_dram_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_page(req_page), .refresh_mode_cbr(refresh_mode_cbr), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done), .pins(pins),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  fpm_dram_model u_mem (.pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 90000) begin
      miscompares++;
      final_report();
    end
  end
  always @(negedge pins.ras_n) ras_falls++;
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Notes the expected read, then holds the request until taken
  task automatic access(input logic w, input logic [8:0] r, input logic [8:0] c,
      input logic [3:0] ln, input logic [31:0] d, input logic pg);
    bit [17:0] k;
    k = {r, c};
    if (!ref_m.exists(k)) ref_m[k] = {14'h0, k};
    for (int i = 0; i < 4; i++) begin
      if (w && ln[i]) ref_m[k][8*i+:8] = d[8*i+:8];
    end
    if (!w) exp_q.push_back(ref_m[k]);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{w, r, c, ln, d};
    req_page = pg;
    for (int n = 0; n < 5000 && req_ready !== 1'b1; n++) @(negedge clk_sys);
    if (req_ready !== 1'b1) check(32'h0, 32'h1);
  endtask
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1 && exp_q.size() > 0) check(rd_data, exp_q.pop_front());
    else if (rd_valid === 1'b1) check(32'h1, 32'h0);
  end
  initial begin
    logic [31:0] v;
    logic [8:0] r;
    logic [8:0] c;
    int base;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int n = 0; n < 25000 && init_done !== 1'b1; n++) @(negedge clk_sys);
    check({31'h0, init_done}, 32'h1);
    check({31'h0, cyc > fpm_dram_pkg::POWERUP_CYC}, 32'h1);
    check({31'h0, ras_falls >= 8}, 32'h1);
    for (int m = 0; m < 2; m++) begin
      refresh_mode_cbr = m[0];
      for (int i = 0; i < 6; i++) begin
        v = rnd();
        r = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : v[8:0];
        c = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : v[17:9];
        access(1'b1, r, c, (i < 2) ? 4'hF : v[21:18], rnd(), 1'b0);
        access(1'b0, r, c, 4'hF, 32'h0, 1'b0);
      end
      for (int j = 0; j < 8; j++) begin
        access(j < 4, r, c + 9'(j % 4), 4'hF, rnd(), (j % 4) != 3);
      end
      @(negedge clk_sys);
      req_valid = 1'b0;
      base = ras_falls;
      repeat (2 * fpm_dram_pkg::REFRESH_INTERVAL_CYC + 200) @(negedge clk_sys);
      check({31'h0, ras_falls - base >= 2}, 32'h1);
    end
    check(32'(exp_q.size()), 32'h0);
    final_report();
  end
endmodule
bind fpm_dram_ctrl fpm_dram_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .req_ready(req_ready), .init_done(init_done), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe));
